/* rtl/rcd_ref_clock_out.sv */
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rcd_ref_clock_out #(
   parameter int ADDR_W = 4
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [15:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [15:0]            rdata_o,
   input  wire logic              prim_osc_tick_i,
   input  wire logic              crystal_enabled_i,
   input  wire logic              sleep_i,
   output logic                   ref_clock_out_pin_o,
   output logic                   ref_clock_out_pin_oe_o
);

   logic [15:0]                   ctrl_ff;
   logic [15:0]                   rdata_ff;
   logic [2:0]                    tick_sync_ff;
   logic [rcd_pkg::CNT_W-1:0]     div_cnt_ff;
   logic                          out_ff;
   logic                          oe_ff;
   rcd_pkg::rcd_ctrl_t            ctrl;
   logic                          hit_ctrl;
   logic                          prim_edge;
   logic                          base_tick;
   logic                          running;
   logic [rcd_pkg::CNT_W-1:0]     nxt_div_cnt;
   logic                          nxt_out;
   logic                          div_bit;

   // Field view of the control word
   assign ctrl.out_enable     = ctrl_ff[rcd_pkg::OUT_EN_BIT];
   assign ctrl.run_in_sleep   = ctrl_ff[rcd_pkg::RUN_SLEEP_BIT];
   assign ctrl.source_select  = ctrl_ff[rcd_pkg::SRC_SEL_BIT];
   assign ctrl.divisor_select = ctrl_ff[rcd_pkg::DIV_LSB +: rcd_pkg::DIV_W];
   assign hit_ctrl            = (addr_i == ADDR_W'(rcd_pkg::CTRL_ADDR));

   // Register write; unimplemented bits masked so they never store
   // mask unimplemented bits
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_ff <= rcd_pkg::CTRL_RESET;
      end else if (wr_i && hit_ctrl) begin
         ctrl_ff <= wdata_i & rcd_pkg::CTRL_WRITE_MASK;
      end
   end

   // Read data one cycle later, zero for unmapped addresses
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 16'h0000;
      end else if (rd_i) begin
         rdata_ff <= hit_ctrl ? ctrl_ff : 16'h0000;
      end else begin
         rdata_ff <= 16'h0000;
      end
   end
   assign rdata_o = rdata_ff;

   // Primary oscillator arrives asynchronously; three-stage synchroniser
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tick_sync_ff <= 3'h0;
      end else begin
         tick_sync_ff <= {tick_sync_ff[1:0], prim_osc_tick_i};
      end
   end
   // Rising edge once stages two and three disagree (third still low)
   assign prim_edge = tick_sync_ff[1] & ~tick_sync_ff[2];

   // system clock path follows whatever sys_clk_i currently is
   // primary path only counts while the crystal is enabled
   assign base_tick = ctrl.source_select ? (prim_edge & crystal_enabled_i) : 1'b1;

   // stop in sleep unless run-in-sleep is set
   assign running = ctrl.out_enable & (~sleep_i | ctrl.run_in_sleep);

   // output toggles from counter bit code-1 giving divide by 2**code
   // code 1 is /2 via bit 0; code 0 toggles every base tick
   assign nxt_div_cnt = running ? (div_cnt_ff + (base_tick ? 15'h0001 : 15'h0000)) : 15'h0000;
   assign div_bit     = (ctrl.divisor_select == 4'h0) ? 1'b0
                        : div_cnt_ff[ctrl.divisor_select - 4'h1];
   assign nxt_out     = ~running ? 1'b0
                        : (ctrl.divisor_select == 4'h0) ? (base_tick ? ~out_ff : out_ff)
                        : div_bit;

   // Divider and pin registers; pin held low while stopped
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         div_cnt_ff <= 15'h0000;
         out_ff     <= 1'b0;
         oe_ff      <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         out_ff     <= nxt_out;
         oe_ff      <= ctrl.out_enable;
      end
   end
   assign ref_clock_out_pin_o    = out_ff;
   assign ref_clock_out_pin_oe_o = oe_ff;

   // Assertions
   // unimplemented bits always read zero
   a_reserved_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rdata_o & ~rcd_pkg::CTRL_WRITE_MASK) == 16'h0000)
      else $error("reserved bits read nonzero");
   a_disabled_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !ctrl.out_enable |=> !ref_clock_out_pin_o)
      else $error("pin toggled while disabled");
   // sleep without run bit stops output
   a_sleep_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (sleep_i && !ctrl.run_in_sleep) |=> !ref_clock_out_pin_o)
      else $error("pin ran during sleep");
   // divide by four on system clock toggles every two cycles
   sequence s_div4_steady;
      running && !ctrl.source_select && ctrl.divisor_select == 4'h2 && !rst_i;
   endsequence
   a_div4_period: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (s_div4_steady [*4]) |-> (ref_clock_out_pin_o != $past(ref_clock_out_pin_o, 2)))
      else $error("divide by four period wrong");
   // code 0 toggles every cycle on system clock
   a_undivided: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (running && !ctrl.source_select && ctrl.divisor_select == 4'h0) ##1
      (running && !ctrl.source_select && ctrl.divisor_select == 4'h0)
      |-> ref_clock_out_pin_o != $past(ref_clock_out_pin_o))
      else $error("undivided clock not toggling");
   // primary source without ticks keeps counter still
   a_prim_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (running && ctrl.source_select && !prim_edge) |=> div_cnt_ff == $past(div_cnt_ff))
      else $error("counter moved without oscillator edge");
   a_xtal_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ctrl.source_select && !crystal_enabled_i && running) |=> div_cnt_ff == $past(div_cnt_ff))
      else $error("counted with crystal off");
   a_sys_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (running && !ctrl.source_select) ##1 running |-> div_cnt_ff == $past(div_cnt_ff) + 15'h0001)
      else $error("system clock path missed a cycle");

endmodule : rcd_ref_clock_out

/* pkg/rcd_pkg.sv */
package rcd_pkg;

   // Register map: one 16-bit control register on the plain port
   localparam logic [3:0]  CTRL_ADDR       = 4'h0;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'hBF00;
   localparam int          OUT_EN_BIT      = 15;
   localparam int          RUN_SLEEP_BIT   = 13;
   localparam int          SRC_SEL_BIT     = 12;
   localparam int          DIV_LSB         = 8;
   localparam int          DIV_W           = 4;
   localparam int          CNT_W           = 15;
   localparam int          CLK_HZ          = 40_000_000;

   // Decoded control fields
   typedef struct packed {
      logic             out_enable;
      logic             run_in_sleep;
      logic             source_select;
      logic [DIV_W-1:0] divisor_select;
   } rcd_ctrl_t;

endpackage : rcd_pkg

/* sim/rcd_ref_clock_out_tb.sv */
`timescale 1ns/1ps
module rcd_ref_clock_out_tb;
   logic        sys_clk_i              = 1'b0;
   logic        rst_i                  = 1'b1;
   logic [3:0]  addr_i                 = 4'h0;
   logic [15:0] wdata_i                = 16'h0000;
   logic        wr_i                   = 1'b0;
   logic        rd_i                   = 1'b0;
   logic        prim_osc_tick_i        = 1'b0;
   logic        crystal_enabled_i      = 1'b1;
   logic        sleep_i                = 1'b0;
   logic [15:0] rdata_o;
   logic        ref_clock_out_pin_o;
   logic        ref_clock_out_pin_oe_o;
   logic [2:0]  osc_cnt_ff             = 3'h0;
   int          fail_count             = 0;
   int          total_checks           = 0;
   int          p;
   rcd_ref_clock_out rcd_ref_clock_out_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prim_osc_tick_i(prim_osc_tick_i),
      .crystal_enabled_i(crystal_enabled_i), .sleep_i(sleep_i), .ref_clock_out_pin_o(ref_clock_out_pin_o),
      .ref_clock_out_pin_oe_o(ref_clock_out_pin_oe_o));
   // Clock, and a slow square wave standing in for the oscillator
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      osc_cnt_ff      <= osc_cnt_ff + 3'h1;
      prim_osc_tick_i <= osc_cnt_ff[2];
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i   <= 1'b0;
      #1 chk(rdata_o, exp);
      @(posedge sys_clk_i);
   endtask : rd
   // Cycles between two rising pin edges; 0 when the pin never rises
   task automatic period(output int per);
      int   n;
      int   t0;
      logic q;
      q   = 1'b1;
      t0  = -1;
      per = 0;
      for (n = 0; n < 400 && per == 0; n++) begin
         @(posedge sys_clk_i);
         #1 if (q === 1'b0 && ref_clock_out_pin_o === 1'b1) begin
            if (t0 >= 0) per = n - t0; else t0 = n;
         end
         q = ref_clock_out_pin_o;
      end
      @(posedge sys_clk_i);
   endtask : period
   task automatic tally_and_finish;
      if (fail_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // Main sequence; each step builds on the control value left by the last
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rd(4'h0, 16'h0000);
      #1 chk({ref_clock_out_pin_oe_o, ref_clock_out_pin_o}, 16'h0000);
      @(posedge sys_clk_i);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'hBF00);
      wr(4'h1, 16'h0000);
      rd(4'h0, 16'hBF00);
      rd(4'h1, 16'h0000);
      for (int c = 0; c < 6; c++) begin
         wr(4'h0, {8'h8 << 4 | 8'(c), 8'h00});
         period(p);
         chk(16'(p), (c == 0) ? 16'h0002 : 16'h0001 << c);
      end
      #1 chk({15'h0000, ref_clock_out_pin_oe_o}, 16'h0001);
      @(posedge sys_clk_i);
      wr(4'h0, 16'h8200);
      sleep_i <= 1'b1;
      period(p);
      chk(16'(p), 16'h0000);
      wr(4'h0, 16'hA200);
      period(p);
      chk(16'(p), 16'h0004);
      sleep_i <= 1'b0;
      wr(4'h0, 16'h9200);
      period(p);
      chk(16'(p), 16'h0020);
      // Crystal off: primary path must freeze the divider
      crystal_enabled_i <= 1'b0;
      period(p);
      chk(16'(p), 16'h0000);
      crystal_enabled_i <= 1'b1;
      wr(4'h0, 16'h0200);
      repeat (3) @(posedge sys_clk_i);
      #1 chk({ref_clock_out_pin_oe_o, ref_clock_out_pin_o}, 16'h0000);
      tally_and_finish;
   end
   // Watchdog well beyond the roughly one thousand cycles the sequence needs
   initial begin
      #(25 * 20000);
      fail_count++;
      tally_and_finish;
   end
endmodule : rcd_ref_clock_out_tb
